// >>> core/hisc_core.sv
// rear-panel switch decoder, host character path and pass-through
// What this block does
// - four switches give the serial rate as a binary code, one bit each
// - parity switch on makes character bit 7 parity, off makes it data
// - with parity on, odd switch selects odd checking, off selects even
// - switch 6 selects direct connection (0) or pass-through (1)
// - direct connection powers up enabled to execute plotting instructions
// - pass-through powers up disabled and forwards terminal-host traffic
// - after enable instruction in pass-through, all known instructions run
// - colour-grouping switch on draws all buffered same-colour vectors first
// - colour-grouping switch off lets the host turn grouping on or off
// - expand switch on enlarges plot area under the pinch wheels
// - test switch 11 selects self-test and remaps front-panel buttons
// - with bus module fitted, five switches give the bus address
// - factory address 05 answers listen '%' and talk 'E'
// - all five address switches on gives listen-only, accepting all bytes
// - listen-only never talks and answers no serial or parallel poll
// - serial switches 7 to 10 still act while the bus port is used
`timescale 1ns/1ns
`include "hisc_map.svh"

module hisc_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// fill side
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	// drain side
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW:0] wr_ptr_ff, rd_ptr_ff;
	logic full, empty;
	// refuse depths the pointer wrap cannot serve
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("hisc_fifo depth must be a power of two, at least 2");
	end
	// honest full and empty from pointers with wrap bit
	assign empty = (wr_ptr_ff == rd_ptr_ff);
	assign full = (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]) &&
		(wr_ptr_ff[AW] != rd_ptr_ff[AW]);
	assign o_ready = !full;
	assign o_valid = !empty;
	assign o_data = mem_ff[rd_ptr_ff[AW-1:0]];
	// storage
	always_ff @(posedge i_clk) begin
		if (i_valid && !full) begin
			mem_ff[wr_ptr_ff[AW-1:0]] <= i_data;
		end
	end
	// write pointer
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			wr_ptr_ff <= '0;
		end else if (i_valid && !full) begin
			wr_ptr_ff <= wr_ptr_ff + 1'b1;
		end
	end
	// read pointer
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			rd_ptr_ff <= '0;
		end else if (i_ready && !empty) begin
			rd_ptr_ff <= rd_ptr_ff + 1'b1;
		end
	end
endmodule : hisc_fifo
module hisc_core #(
	parameter int FIFO_DEPTH = 32
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// rear-panel switches, asynchronous
	input wire logic [`HISC_SER_SW_W-1:0] i_ser_sw,
	input wire logic [`HISC_BUS_SW_W-1:0] i_bus_sw,
	input wire logic i_bus_fitted,
	// host characters from the serial receiver
	input wire logic i_rx_valid,
	output logic o_rx_ready,
	input wire logic [7:0] i_rx_data,
	// characters to the instruction interpreter
	output logic o_cmd_valid,
	input wire logic i_cmd_ready,
	output hisc_pkg::hisc_chr_type o_cmd,
	// interpreter events
	input wire logic i_plot_on,
	input wire logic i_plot_off,
	input wire logic i_sort_cmd,
	input wire logic i_sort_val,
	// pass-through traffic
	input wire logic i_term_valid,
	input wire logic [7:0] i_term_data,
	output logic o_term_valid,
	output logic [7:0] o_term_data,
	output logic o_host_valid,
	output logic [7:0] o_host_data,
	// decoded serial settings
	output hisc_pkg::hisc_ser_cfg_type o_ser_cfg,
	output logic o_plot_en,
	output logic o_pen_sort,
	output logic o_panel_diag,
	// bus port settings and gating
	input wire logic i_talk_req,
	output hisc_pkg::hisc_bus_cfg_type o_bus_cfg,
	output logic o_bus_en,
	output logic [7:0] o_listen_chr,
	output logic [7:0] o_talk_chr,
	output logic o_talk_active,
	output logic o_poll_en,
	output logic o_cfg_valid
);
	import hisc_pkg::*;
	// parity test: high when the character fails the selected sense
	function automatic logic par_bad(input logic [7:0] d, input logic odd);
		par_bad = ((^d) != odd);
	endfunction : par_bad
	logic [`HISC_SER_SW_W-1:0] ser_s1_ff, ser_s2_ff;
	logic [`HISC_BUS_SW_W-1:0] bus_s1_ff, bus_s2_ff;
	logic fit_s1_ff, fit_s2_ff;
	logic [1:0] settle_ff;
	logic cfg_valid_ff;
	hisc_ser_cfg_type ser_cfg_ff;
	hisc_bus_cfg_type bus_cfg_ff;
	logic bus_en_ff, plot_en_ff, prog_sort_ff, talk_ff;
	logic [7:0] term_data_ff, host_data_ff;
	logic term_valid_ff, host_valid_ff;
	logic capture, rx_take, passing, fifo_ready;
	hisc_chr_type nxt_chr;
	logic [4:0] sw_addr;
	// refuse a buffer smaller than a useful burst
	if (FIFO_DEPTH < 2) begin : g_chk
		$error("hisc_core needs FIFO_DEPTH of at least 2");
	end
	// two-flop synchronisers; first stage feeds only the second
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			ser_s1_ff <= '0;
			ser_s2_ff <= '0;
			bus_s1_ff <= '0;
			bus_s2_ff <= '0;
			fit_s1_ff <= 1'b0;
			fit_s2_ff <= 1'b0;
		end else begin
			ser_s1_ff <= i_ser_sw;
			ser_s2_ff <= ser_s1_ff;
			bus_s1_ff <= i_bus_sw;
			bus_s2_ff <= bus_s1_ff;
			fit_s1_ff <= i_bus_fitted;
			fit_s2_ff <= fit_s1_ff;
		end
	end
	// wait for the synchronisers to fill, then capture once
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			settle_ff <= '0;
			cfg_valid_ff <= 1'b0;
		end else begin
			if (settle_ff != `HISC_SETTLE) begin
				settle_ff <= settle_ff + 1'b1;
			end
			cfg_valid_ff <= cfg_valid_ff || capture;
		end
	end
	assign capture = !cfg_valid_ff && (settle_ff == `HISC_SETTLE);
	assign sw_addr = bus_s2_ff[`HISC_BSW_ADDR_MSB:`HISC_BSW_ADDR_LSB];
	// serial settings latched once at capture; 7..10 decoded for both ports
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			ser_cfg_ff <= '0;
		end else if (capture) begin
			ser_cfg_ff.baud <=
				ser_s2_ff[`HISC_SW_BAUD_MSB:`HISC_SW_BAUD_LSB];
			ser_cfg_ff.parity_en <= ser_s2_ff[`HISC_SW_PARITY];
			ser_cfg_ff.parity_odd <= ser_s2_ff[`HISC_SW_ODD];
			ser_cfg_ff.eavesdrop <= ser_s2_ff[`HISC_SW_EAVES];
			ser_cfg_ff.pen_sort <= ser_s2_ff[`HISC_SW_PENSORT];
			ser_cfg_ff.expand <= ser_s2_ff[`HISC_SW_EXPAND];
			ser_cfg_ff.diag <=
				ser_s2_ff[`HISC_SW_DIAG_MSB:`HISC_SW_DIAG_LSB];
			ser_cfg_ff.test <= ser_s2_ff[`HISC_SW_TEST];
		end
	end
	// bus address and listen-only decode
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			bus_cfg_ff <= '0;
			bus_en_ff <= 1'b0;
		end else if (capture) begin
			bus_en_ff <= fit_s2_ff;
			bus_cfg_ff.addr <= sw_addr;
			bus_cfg_ff.listen_only <=
				(sw_addr == `HISC_LISTEN_ONLY_ADDR);
			bus_cfg_ff.rsvd_on <= bus_s2_ff[`HISC_BSW_RSVD];
		end
	end
	// plotter enable: direct starts on, pass-through starts off
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			plot_en_ff <= 1'b0;
		end else if (capture) begin
			plot_en_ff <= !ser_s2_ff[`HISC_SW_EAVES];
		end else if (!ser_cfg_ff.eavesdrop) begin
			plot_en_ff <= 1'b1;
		end else if (i_plot_on) begin
			plot_en_ff <= 1'b1;
		end else if (i_plot_off) begin
			plot_en_ff <= 1'b0;
		end
	end
	// programmed colour grouping, honoured only with switch off
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			prog_sort_ff <= 1'b0;
		end else if (i_sort_cmd) begin
			prog_sort_ff <= i_sort_val;
		end
	end
	// talk is granted only to an addressed, fitted bus port
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			talk_ff <= 1'b0;
		end else begin
			talk_ff <= i_talk_req && bus_en_ff &&
				!bus_cfg_ff.listen_only;
		end
	end
	// character entering the buffer: parity sense and execute mark
	assign rx_take = i_rx_valid && o_rx_ready && cfg_valid_ff;
	assign passing = ser_cfg_ff.eavesdrop && !plot_en_ff;
	always_comb begin
		nxt_chr.data = i_rx_data;
		nxt_chr.parity_err = 1'b0;
		nxt_chr.exec = plot_en_ff;
		if (ser_cfg_ff.parity_en) begin
			nxt_chr.data[`HISC_CHR_PAR_BIT] = 1'b0;
			nxt_chr.parity_err =
				par_bad(i_rx_data, ser_cfg_ff.parity_odd);
		end
	end
	// host to terminal forwarding while disabled
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			term_valid_ff <= 1'b0;
			term_data_ff <= `HISC_RST_BYTE;
		end else begin
			term_valid_ff <= rx_take && passing;
			if (rx_take && passing) begin
				term_data_ff <= i_rx_data;
			end
		end
	end
	// terminal to host forwarding while disabled
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			host_valid_ff <= 1'b0;
			host_data_ff <= `HISC_RST_BYTE;
		end else begin
			host_valid_ff <= i_term_valid && passing;
			if (i_term_valid && passing) begin
				host_data_ff <= i_term_data;
			end
		end
	end
	// buffer between receiver and interpreter; back-pressure to receiver
	hisc_fifo #(
		.WIDTH($bits(hisc_chr_type)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_valid(i_rx_valid && cfg_valid_ff),
		.o_ready(fifo_ready),
		.i_data(nxt_chr),
		.o_valid(o_cmd_valid),
		.i_ready(i_cmd_ready),
		.o_data(o_cmd)
	);
	// outputs; no ready before settings latch, so no char is lost
	assign o_rx_ready = fifo_ready && cfg_valid_ff;
	assign o_ser_cfg = ser_cfg_ff;
	assign o_bus_cfg = bus_cfg_ff;
	assign o_bus_en = bus_en_ff;
	assign o_cfg_valid = cfg_valid_ff;
	assign o_plot_en = plot_en_ff;
	assign o_pen_sort = ser_cfg_ff.pen_sort || prog_sort_ff;
	assign o_panel_diag = ser_cfg_ff.test;
	assign o_listen_chr = `HISC_LISTEN_BASE | {3'h0, bus_cfg_ff.addr};
	assign o_talk_chr = `HISC_TALK_BASE | {3'h0, bus_cfg_ff.addr};
	assign o_talk_active = talk_ff;
	assign o_poll_en = bus_en_ff && !bus_cfg_ff.listen_only;
	assign o_term_valid = term_valid_ff;
	assign o_term_data = term_data_ff;
	assign o_host_valid = host_valid_ff;
	assign o_host_data = host_data_ff;
	// settings appear one edge after capture, three edges after reset release
	property p_baud;
		@(posedge i_clk) disable iff (!i_nrst)
		capture |=> o_ser_cfg.baud == $past(ser_s2_ff[3:0]);
	endproperty
	a_baud: assert property (p_baud) else $error("baud code mismatch");
	property p_capture_time;
		@(posedge i_clk) $rose(i_nrst) |-> !o_cfg_valid ##3 o_cfg_valid;
	endproperty
	a_capture_time: assert property (p_capture_time)
		else $error("settings not latched on time");
	property p_parity;
		@(posedge i_clk) disable iff (!i_nrst)
		(rx_take && o_ser_cfg.parity_en) |->
			!nxt_chr.data[7] && (nxt_chr.parity_err ==
			((^i_rx_data) != o_ser_cfg.parity_odd));
	endproperty
	a_parity: assert property (p_parity)
		else $error("parity check wrong");
	property p_no_parity;
		@(posedge i_clk) disable iff (!i_nrst)
		(rx_take && !o_ser_cfg.parity_en) |->
			nxt_chr.data == i_rx_data && !nxt_chr.parity_err;
	endproperty
	a_no_parity: assert property (p_no_parity)
		else $error("bit 7 not kept as data");
	property p_direct_on;
		@(posedge i_clk) disable iff (!i_nrst)
		(o_cfg_valid && !o_ser_cfg.eavesdrop) |-> o_plot_en;
	endproperty
	a_direct_on: assert property (p_direct_on)
		else $error("direct mode not enabled");
	property p_pass_fwd;
		@(posedge i_clk) disable iff (!i_nrst)
		(i_term_valid && passing) |=>
			o_host_valid && o_host_data == $past(i_term_data);
	endproperty
	a_pass_fwd: assert property (p_pass_fwd)
		else $error("terminal byte not forwarded");
	property p_plot_on;
		@(posedge i_clk) disable iff (!i_nrst)
		(o_cfg_valid && !capture && i_plot_on) |=> o_plot_en [*2];
	endproperty
	a_plot_on: assert property (p_plot_on)
		else $error("enable instruction ignored");
	property p_listen_only;
		@(posedge i_clk) disable iff (!i_nrst)
		o_bus_cfg.listen_only |-> !o_poll_en ##1 !o_talk_active;
	endproperty
	a_listen_only: assert property (p_listen_only)
		else $error("listen-only port talks or polls");
	property p_chars;
		@(posedge i_clk) disable iff (!i_nrst)
		o_bus_cfg.addr == 5'h05 |->
			o_listen_chr == 8'h25 && o_talk_chr == 8'h45;
	endproperty
	a_chars: assert property (p_chars)
		else $error("listen or talk character wrong");
endmodule : hisc_core

// >>> include/hisc_map.svh
// switch positions, reset values and timing counts for the switch decoder
`ifndef HISC_MAP_SVH
`define HISC_MAP_SVH
// serial rear-panel switch positions
`define HISC_SW_BAUD_LSB 0
`define HISC_SW_BAUD_MSB 3
`define HISC_SW_PARITY 4
`define HISC_SW_ODD 5
`define HISC_SW_EAVES 6
`define HISC_SW_PENSORT 7
`define HISC_SW_EXPAND 8
`define HISC_SW_DIAG_LSB 9
`define HISC_SW_DIAG_MSB 10
`define HISC_SW_TEST 11
`define HISC_SER_SW_W 12
// bus-panel switch positions
`define HISC_BSW_ADDR_LSB 0
`define HISC_BSW_ADDR_MSB 4
`define HISC_BSW_RSVD 5
`define HISC_BUS_SW_W 6
// data character layout
`define HISC_CHR_PAR_BIT 7
// all-ones address means listen-only
`define HISC_LISTEN_ONLY_ADDR 5'h1F
// base codes for listen and talk characters
`define HISC_LISTEN_BASE 8'h20
`define HISC_TALK_BASE 8'h40
// reset values
`define HISC_RST_BYTE 8'h00
`define HISC_RST_ADDR 5'h00
// edges after reset release before synchronised switches are valid
`define HISC_SETTLE 2'h2
`endif

// >>> include/hisc_pkg.sv
// types shared by the switch decoder and its ports
package hisc_pkg;
	typedef struct packed {
		logic [3:0] baud;
		logic parity_en;
		logic parity_odd;
		logic eavesdrop;
		logic pen_sort;
		logic expand;
		logic [1:0] diag;
		logic test;
	} hisc_ser_cfg_type;
	typedef struct packed {
		logic [4:0] addr;
		logic listen_only;
		logic rsvd_on;
	} hisc_bus_cfg_type;
	typedef struct packed {
		logic [7:0] data;
		logic parity_err;
		logic exec;
	} hisc_chr_type;
endpackage : hisc_pkg

// >>> sim/hisc_host.sv
// host computer model that offers characters to the switch decoder
`timescale 1ns/1ns
module hisc_host (
	// clock
	input wire logic i_clk,
	// character link towards the decoder
	input wire logic i_ready,
	output logic o_valid,
	output logic [7:0] o_data
);
	// quiet line at start
	initial begin
		o_valid = 1'b0;
		o_data = 8'h00;
	end
	// stall for gap cycles, offer one byte, hold it until taken
	task automatic send(input logic [7:0] b, input int gap);
		repeat (gap) begin
			@(negedge i_clk);
			o_data = ~o_data;
		end
		@(negedge i_clk);
		o_valid = 1'b1;
		o_data = b;
		while (i_ready !== 1'b1) @(negedge i_clk);
		@(posedge i_clk);
		@(negedge i_clk);
		// released line shows the inverse, not the last byte
		o_valid = 1'b0;
		o_data = ~b;
	endtask : send
endmodule : hisc_host

// >>> sim/test_hisc_core.sv
// self-checking bench for the switch decoder
`timescale 1ns/1ns
module test_hisc_core;
	import hisc_pkg::*;
	logic i_clk, i_nrst, i_bus_fitted, i_rx_valid, o_rx_ready;
	logic [11:0] i_ser_sw;
	logic [5:0] i_bus_sw;
	logic [7:0] i_rx_data, i_term_data, o_term_data, o_host_data;
	logic [7:0] o_listen_chr, o_talk_chr;
	logic o_cmd_valid, i_cmd_ready, i_plot_on, i_plot_off, i_sort_cmd;
	logic i_sort_val, i_term_valid, o_term_valid, o_host_valid, o_plot_en;
	logic o_pen_sort, o_panel_diag, i_talk_req, o_bus_en, o_talk_active;
	logic o_poll_en, o_cfg_valid;
	hisc_chr_type o_cmd;
	hisc_ser_cfg_type o_ser_cfg;
	hisc_bus_cfg_type o_bus_cfg;
	int bad_count = 0;
	int n_compared = 0;
	// design and host model
	hisc_core #(.FIFO_DEPTH(32)) uut (.*);
	hisc_host host (.i_clk(i_clk), .i_ready(o_rx_ready),
		.o_valid(i_rx_valid), .o_data(i_rx_data));
	// 100 MHz clock
	always #5 i_clk = ~i_clk;
	// compare any value up to 16 bits
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// print counts and verdict, then stop
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up
	// reset for five cycles with the given switches, wait for capture
	task automatic boot(input logic [11:0] s, input logic [5:0] b,
		input logic f);
		int k;
		@(negedge i_clk);
		i_nrst = 1'b0;
		i_ser_sw = s;
		i_bus_sw = b;
		i_bus_fitted = f;
		repeat (5) @(negedge i_clk);
		chk(o_rx_ready, 1'b0);
		i_nrst = 1'b1;
		k = 0;
		while (o_cfg_valid !== 1'b1 && k < 10) begin
			@(negedge i_clk);
			k++;
		end
		chk(o_cfg_valid, 1'b1);
	endtask : boot
	// take one character from the interpreter side and judge it
	task automatic pop(input logic [9:0] exp);
		chk(o_cmd_valid, 1'b1);
		chk(o_cmd, exp);
		i_cmd_ready = 1'b1;
		@(negedge i_clk);
		i_cmd_ready = 1'b0;
		// let an edge pass so a following pop raises ready afresh
		@(negedge i_clk);
	endtask : pop
	// one terminal byte, judge forwarding to the host
	task automatic term(input logic [7:0] b, input logic fwd);
		@(negedge i_clk);
		i_term_valid = 1'b1;
		i_term_data = b;
		@(negedge i_clk);
		i_term_valid = 1'b0;
		chk(o_host_valid, fwd);
		if (fwd)
			chk(o_host_data, b);
	endtask : term
	// direct install, odd parity, grouping, expand, test, bus address 05
	task automatic t_direct;
		boot(12'h9BA, 6'h05, 1'b1);
		chk(o_ser_cfg, {4'hA, 5'b11011, 2'b00, 1'b1});
		chk(o_plot_en, 1'b1);
		chk(o_pen_sort, 1'b1);
		chk(o_ser_cfg.expand, 1'b1);
		chk(o_panel_diag, 1'b1);
		chk(o_bus_cfg, {5'h05, 2'b00});
		chk(o_bus_en, 1'b1);
		chk(o_listen_chr, 8'h25);
		chk(o_talk_chr, 8'h45);
		chk(o_poll_en, 1'b1);
		i_talk_req = 1'b1;
		repeat (2) @(negedge i_clk);
		chk(o_talk_active, 1'b1);
		i_talk_req = 1'b0;
		host.send(8'hC1, 0);
		pop({8'h41, 1'b0, 1'b1});
		i_ser_sw = 12'h000;
		i_bus_sw = 6'h1F;
		repeat (4) @(negedge i_clk);
		chk(o_ser_cfg, {4'hA, 5'b11011, 2'b00, 1'b1});
		chk(o_bus_cfg, {5'h05, 2'b00});
	endtask : t_direct
	// pass-through install, no parity, listen-only bus address
	task automatic t_eaves;
		boot(12'h045, 6'h1F, 1'b1);
		chk(o_ser_cfg, {4'h5, 5'b00100, 2'b00, 1'b0});
		chk(o_plot_en, 1'b0);
		chk(o_bus_cfg, {5'h1F, 2'b10});
		chk(o_poll_en, 1'b0);
		i_talk_req = 1'b1;
		repeat (3) @(negedge i_clk);
		chk(o_talk_active, 1'b0);
		i_talk_req = 1'b0;
		term(8'h5A, 1'b1);
		host.send(8'hC1, 1);
		chk(o_term_valid, 1'b1);
		chk(o_term_data, 8'hC1);
		pop({8'hC1, 1'b0, 1'b0});
		chk(o_pen_sort, 1'b0);
		i_sort_cmd = 1'b1;
		i_sort_val = 1'b1;
		@(negedge i_clk);
		i_sort_cmd = 1'b0;
		chk(o_pen_sort, 1'b1);
		i_sort_cmd = 1'b1;
		i_sort_val = 1'b0;
		@(negedge i_clk);
		i_sort_cmd = 1'b0;
		chk(o_pen_sort, 1'b0);
		i_plot_on = 1'b1;
		@(negedge i_clk);
		i_plot_on = 1'b0;
		chk(o_plot_en, 1'b1);
		term(8'h33, 1'b0);
		host.send(8'h4C, 0);
		pop({8'h4C, 1'b0, 1'b1});
		i_plot_off = 1'b1;
		@(negedge i_clk);
		i_plot_off = 1'b0;
		chk(o_plot_en, 1'b0);
	endtask : t_eaves
	// even parity, fill the buffer until refused, then drain in order
	task automatic t_fifo;
		logic [7:0] b;
		boot(12'h010, 6'h05, 1'b0);
		chk(o_bus_en, 1'b0);
		for (int i = 0; i < 32; i++)
			host.send(8'h80 ^ 8'(i * 7), i % 3);
		chk(o_rx_ready, 1'b0);
		for (int i = 0; i < 32; i++) begin
			b = 8'h80 ^ 8'(i * 7);
			pop({1'b0, b[6:0], ^b, 1'b1});
		end
		chk(o_cmd_valid, 1'b0);
		chk(o_rx_ready, 1'b1);
	endtask : t_fifo
	// main sequence
	initial begin
		i_clk = 1'b0;
		i_nrst = 1'b0;
		i_ser_sw = 12'h000;
		i_bus_sw = 6'h00;
		i_bus_fitted = 1'b0;
		i_cmd_ready = 1'b0;
		i_plot_on = 1'b0;
		i_plot_off = 1'b0;
		i_sort_cmd = 1'b0;
		i_sort_val = 1'b0;
		i_term_valid = 1'b0;
		i_term_data = 8'h00;
		i_talk_req = 1'b0;
		t_direct();
		t_eaves();
		t_fifo();
		wrap_up();
	end
	// cut a hang short
	initial begin
		#200000;
		bad_count++;
		wrap_up();
	end
endmodule : test_hisc_core
